// ==== verif/ppr_sensor_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module ppr_sensor_model
    import ppr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Process level and sensed value
    input  wire logic [15:0] level,
    output logic      [15:0] feedbackIn
);

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter saturates at full scale
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            feedbackIn <= 16'h0000;
        end else begin
            feedbackIn <= (level > PCT_MAX) ? PCT_MAX : level;
        end
    end

endmodule : ppr_sensor_model

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench
    import ppr_pkg::*;
;
    localparam int BC = 20;

    logic        clk_sys;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        runIn;
    logic        multiFunctionInput;
    logic [15:0] setpointIn;
    logic [15:0] feedbackIn;
    logic [15:0] level;
    logic [15:0] freqCmd;
    logic        feedbackLossFault;
    int          mismatches;
    int          num_checks;

    ppr_regulator #(.BEAT_CYCLES(BC)) i_ppr_regulator (
        .clk_sys(clk_sys), .srst(srst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .runIn(runIn), .multiFunctionInput(multiFunctionInput), .setpointIn(setpointIn),
        .feedbackIn(feedbackIn), .freqCmd(freqCmd), .feedbackLossFault(feedbackLossFault));

    ppr_sensor_model i_ppr_sensor_model (
        .clk_sys(clk_sys), .srst(srst), .level(level), .feedbackIn(feedbackIn));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic beats(input int n);
        repeat (n * BC) @(posedge clk_sys);
    endtask : beats

    function automatic logic [7:0] cfg_addr(input logic [3:0] ix);
        return {2'b00, ix, 2'b00};
    endfunction : cfg_addr

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
        chk_flag(err, 1'b0);
    endtask : rd_chk

    task automatic wait_change(output logic [15:0] v);
        logic [15:0] old;
        int          n;
        old = freqCmd;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (freqCmd === old && n < 10 * BC);
        v = freqCmd;
    endtask : wait_change

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_registers();
        logic [3:0]  ix  [9] = '{IX_CTRL, IX_FBF, IX_OUTF, IX_KP2, IX_TI2, IX_TD2, IX_TH1, IX_TH2, IX_LTH};
        logic [31:0] exp [9] = '{32'h0, 32'h0, 32'h3E8, 32'hC8, 32'hC8, 32'h0, 32'hC8, 32'h320, 32'h0};
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 9; i++) begin
            rd_chk(cfg_addr(ix[i]), exp[i]);
        end
        wr(cfg_addr(IX_KP1), 32'h0000_FFFF);
        rd_chk(cfg_addr(IX_KP1), 32'h0000_270F);
        wr(cfg_addr(IX_TH1), 32'h0000_03E8);
        rd_chk(cfg_addr(IX_TH1), 32'h0000_0320);
        wr(cfg_addr(IX_TH1), 32'h0000_00C8);
        wr(cfg_addr(IX_KP1), 32'h0000_00C8);
        apb_xfer(1'b0, 8'h80, 32'h0, rd, err);
        chk_flag(err, 1'b1);
        chk(rd, 32'h0);
    endtask : t_registers

    task automatic t_hold_and_step();
        logic [15:0] v;
        wr(cfg_addr(IX_OUTF), 32'h0);
        wr(cfg_addr(IX_INIT), 32'h0000_01F4);
        wr(cfg_addr(IX_ITIME), 32'h1);
        runIn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'(freqCmd), 32'h1F4);
        rd_chk(OFS_STATUS, 32'h2);
        beats(8);
        rd_chk(OFS_STATUS, 32'h0);
        chk(32'(freqCmd), 32'h1F4);
        level      <= 16'h0000;
        setpointIn <= 16'h03E8;
        for (int i = 1; i <= 3; i++) begin
            wait_change(v);
            chk(32'(v), 32'(500 + 10 * i));
        end
        runIn              <= 1'b0;
        multiFunctionInput <= 1'b1;
        beats(5);
        chk(32'(freqCmd), 32'h212);
        wr(cfg_addr(IX_CTRL), 32'h4);
        wait_change(v);
        chk(32'(v), 32'h21C);
        wr(cfg_addr(IX_CTRL), 32'h0);
        multiFunctionInput <= 1'b0;
    endtask : t_hold_and_step

    task automatic t_loss();
        beats(60);
        chk_flag(feedbackLossFault, 1'b0);
        wr(cfg_addr(IX_LTIME), 32'h1);
        wr(cfg_addr(IX_LTH), 32'h64);
        beats(30);
        level <= 16'h00C8;
        beats(2);
        level <= 16'h0000;
        beats(30);
        chk_flag(feedbackLossFault, 1'b0);
        beats(30);
        chk_flag(feedbackLossFault, 1'b1);
        level <= 16'h01F4;
        beats(1);
        wr(OFS_STATUS, 32'h1);
        rd_chk(OFS_STATUS, 32'h0);
        wr(cfg_addr(IX_LTH), 32'h0);
    endtask : t_loss

    task automatic t_filter();
        logic [31:0] rd;
        logic        err;
        level <= 16'h03E8;
        beats(2);
        rd_chk(OFS_FBK, 32'h3E8);
        wr(cfg_addr(IX_FBF), 32'h1);
        level <= 16'h0000;
        repeat (BC + BC / 2) @(posedge clk_sys);
        apb_xfer(1'b0, OFS_FBK, 32'h0, rd, err);
        chk_flag(rd > 32'h0 && rd < 32'h3E8, 1'b1);
    endtask : t_filter

    // Start 30 below the target, expect three full steps and then a standstill
    task automatic gain_case(input logic [1:0] mode, input logic term, input logic [15:0] spv,
                             input logic [15:0] lvl, input logic [15:0] exp);
        multiFunctionInput <= term;
        setpointIn         <= spv;
        level              <= lvl;
        wr(cfg_addr(IX_CTRL), {30'h00000000, mode});
        wr(cfg_addr(IX_INIT), {16'h0000, exp - 16'h001E});
        runIn <= 1'b1;
        beats(8);
        chk(32'(freqCmd), {16'h0000, exp});
        runIn <= 1'b0;
    endtask : gain_case

    // Pure proportional loop: set one 20.0, set two 100.0, no integral
    task automatic t_gains();
        wr(cfg_addr(IX_FBF), 32'h0);
        wr(cfg_addr(IX_ITIME), 32'h0);
        wr(cfg_addr(IX_TI1), 32'h0);
        wr(cfg_addr(IX_TI2), 32'h0);
        wr(cfg_addr(IX_KP2), 32'h0000_03E8);
        gain_case(SW_NONE, 1'b1, 16'h03E8, 16'h01F4, 16'h0064);
        gain_case(SW_FREQ, 1'b0, 16'h03E8, 16'h01F4, 16'h0064);
        gain_case(SW_TERM, 1'b0, 16'h03E8, 16'h01F4, 16'h0064);
        gain_case(SW_TERM, 1'b1, 16'h03E8, 16'h01F4, 16'h01F4);
        gain_case(SW_DEV, 1'b0, 16'h02B2, 16'h01F4, 16'h0026);
        gain_case(SW_DEV, 1'b0, 16'h03E8, 16'h0064, 16'h0384);
        gain_case(SW_DEV, 1'b0, 16'h03E8, 16'h01F4, 16'h012C);
        // Slow output filter keeps the command near the initial value
        wr(cfg_addr(IX_OUTF), 32'h1);
        wr(cfg_addr(IX_INIT), 32'h0000_014A);
        runIn <= 1'b1;
        beats(8);
        chk_flag(freqCmd > 16'h012C && freqCmd < 16'h014A, 1'b1);
        runIn <= 1'b0;
    endtask : t_gains

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end

    initial begin
        mismatches = 0;
        num_checks = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        runIn = 1'b0;
        multiFunctionInput = 1'b0;
        setpointIn = 16'h01F4;
        level = 16'h01F4;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        t_registers();
        t_hold_and_step();
        t_loss();
        t_filter();
        t_gains();
        test_done();
    end

endmodule : testbench

`default_nettype wire

// ==== verilog/ppr_pkg.sv ====
`default_nettype none

package ppr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_NS        = 20;
    localparam int BEAT_NS       = 2_000_000;
    localparam int BEAT_CYC      = (BEAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int UNIT_1MS_NS   = 1_000_000;
    localparam int UNIT_10MS_NS  = 10_000_000;
    localparam int UNIT_100MS_NS = 100_000_000;
    localparam int BEATS_10MS    = UNIT_10MS_NS / BEAT_NS;
    localparam int BEATS_100MS   = UNIT_100MS_NS / BEAT_NS;
    localparam int TD_DIV        = BEAT_NS / UNIT_1MS_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic scaling, values in 0.1 percent
    localparam logic [15:0] PCT_MAX  = 16'h03E8;
    localparam int          KP_DIV   = 1000;
    localparam int          FRAC     = 8;
    localparam int          IFRAC    = 10;
    localparam int          STEP_MAX = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, config word n at byte 4*n
    localparam int         NCFG       = 15;
    localparam logic [3:0] IX_CTRL    = 4'h0;
    localparam logic [3:0] IX_FBF     = 4'h1;
    localparam logic [3:0] IX_OUTF    = 4'h2;
    localparam logic [3:0] IX_KP1     = 4'h3;
    localparam logic [3:0] IX_TI1     = 4'h4;
    localparam logic [3:0] IX_TD1     = 4'h5;
    localparam logic [3:0] IX_KP2     = 4'h6;
    localparam logic [3:0] IX_TI2     = 4'h7;
    localparam logic [3:0] IX_TD2     = 4'h8;
    localparam logic [3:0] IX_TH1     = 4'h9;
    localparam logic [3:0] IX_TH2     = 4'hA;
    localparam logic [3:0] IX_INIT    = 4'hB;
    localparam logic [3:0] IX_ITIME   = 4'hC;
    localparam logic [3:0] IX_LTH     = 4'hD;
    localparam logic [3:0] IX_LTIME   = 4'hE;
    localparam logic [7:0] OFS_STATUS = 8'h3C;
    localparam logic [7:0] OFS_OUT    = 8'h40;
    localparam logic [7:0] OFS_FBK    = 8'h44;

    ////////////////////////////////////////////////////////////////////////////
    // Fields and switching modes
    localparam int         CTRL_STOP_BIT = 2;
    localparam int         ST_FAULT_BIT  = 0;
    localparam int         ST_HOLD_BIT   = 1;
    localparam logic [1:0] SW_NONE       = 2'h0;
    localparam logic [1:0] SW_TERM       = 2'h1;
    localparam logic [1:0] SW_DEV        = 2'h2;
    localparam logic [1:0] SW_FREQ       = 2'h3;

    typedef logic [NCFG-1:0][15:0] ppr_cfg_t;

    // Index 14 first, index 0 last
    localparam ppr_cfg_t CFG_RST = {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0320,
                                    16'h00C8, 16'h0000, 16'h00C8, 16'h00C8, 16'h0000,
                                    16'h00C8, 16'h00C8, 16'h03E8, 16'h0000, 16'h0000};
    localparam ppr_cfg_t CFG_MAX = {16'h00C8, 16'h03E8, 16'hFDE8, 16'h03E8, 16'h03E8,
                                    16'h03E8, 16'h2710, 16'h03E8, 16'h270F, 16'h2710,
                                    16'h03E8, 16'h270F, 16'h1770, 16'h1770, 16'h0007};

    typedef enum logic {PH_REG, PH_HOLD} ppr_phase_t;

    typedef struct packed {
        ppr_cfg_t           cfg;
        logic [31:0]        prdata;
        logic [16:0]        beatCnt;
        ppr_phase_t         phase;
        logic               runPrev;
        logic [19:0]        holdCnt;
        logic [15:0]        lossCnt;
        logic               fault;
        logic signed [31:0] fbFilt;
        logic signed [31:0] outFilt;
        logic signed [31:0] integ;
        logic signed [31:0] ePrev;
        logic [15:0]        freq;
    } ppr_state_t;

endpackage : ppr_pkg

`default_nettype wire

// ==== verilog/ppr_regulator.sv ====
`timescale 1ns/10ps
`default_nettype none

module ppr_regulator
    import ppr_pkg::*;
#(
    parameter int BEAT_CYCLES = BEAT_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive state and gain terminal
    input  wire logic        runIn,
    input  wire logic        multiFunctionInput,
    // Process values, 0.1 percent
    input  wire logic [15:0] setpointIn,
    input  wire logic [15:0] feedbackIn,
    // Frequency command and fault
    output logic      [15:0] freqCmd,
    output logic             feedbackLossFault
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic signed [31:0] ppr_s32(input logic [15:0] v);
        return $signed({16'h0000, v});
    endfunction : ppr_s32

    function automatic logic signed [31:0] ppr_clamp(input logic signed [31:0] v,
                                                     input logic signed [31:0] lo,
                                                     input logic signed [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : ppr_clamp

    function automatic logic signed [31:0] ppr_lpf(input logic signed [31:0] y,
                                                   input logic signed [31:0] x,
                                                   input logic signed [31:0] n);
        return (n <= 1) ? x : y + (x - y) / n;
    endfunction : ppr_lpf

    function automatic logic [15:0] ppr_lerp(input logic [15:0] v1, input logic [15:0] v2,
                                             input logic [15:0] pos, input logic [15:0] span);
        logic signed [31:0] r;
        r = ppr_s32(v1);
        if (span != 16'h0000) begin
            r = r + (ppr_s32(v2) - ppr_s32(v1)) * ppr_s32(pos) / ppr_s32(span);
        end
        return r[15:0];
    endfunction : ppr_lerp

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    ppr_state_t         st_q;
    ppr_state_t         st_d;
    logic [3:0]         idx;
    logic               cfgHit;
    logic               mapped;
    logic               wrEn;
    logic [15:0]        wrVal;
    logic [31:0]        rdVal;
    logic               beat;
    logic               calcEn;
    logic               calcBeat;
    logic               runRise;
    logic               lossBelow;
    logic signed [31:0] lossLim;
    logic [1:0]         mode;
    logic [15:0]        sp;
    logic [15:0]        fb;
    logic [15:0]        th1;
    logic [15:0]        th2;
    logic [15:0]        absE;
    logic [15:0]        pos;
    logic [15:0]        span;
    logic [15:0]        kpAct;
    logic [15:0]        tiAct;
    logic [15:0]        tdAct;
    logic signed [31:0] fbF;
    logic signed [31:0] e;
    logic signed [31:0] pTerm;
    logic signed [31:0] iNext;
    logic signed [31:0] dTerm;
    logic signed [31:0] raw;
    logic signed [31:0] outF;
    logic signed [31:0] o;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    assign idx    = paddr[5:2];
    assign cfgHit = (paddr[1:0] == 2'b00) && (paddr < OFS_STATUS);
    assign mapped = cfgHit || paddr == OFS_STATUS || paddr == OFS_OUT || paddr == OFS_FBK;
    assign wrEn   = psel && penable && pwrite;

    always_comb begin
        wrVal = (pwdata > {16'h0000, CFG_MAX[idx]}) ? CFG_MAX[idx] : pwdata[15:0];
        if (idx == IX_TH1 && wrVal > th2) begin
            wrVal = th2;
        end else if (idx == IX_TH2 && wrVal < th1) begin
            wrVal = th1;
        end
    end

    always_comb begin
        rdVal = 32'h00000000;
        if (cfgHit) begin
            rdVal[15:0] = st_q.cfg[idx];
        end else if (paddr == OFS_STATUS) begin
            rdVal[ST_FAULT_BIT] = st_q.fault;
            rdVal[ST_HOLD_BIT]  = st_q.phase == PH_HOLD;
        end else if (paddr == OFS_OUT) begin
            rdVal[15:0] = st_q.freq;
        end else if (paddr == OFS_FBK) begin
            rdVal[15:0] = fbF[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath

    assign beat     = ce && st_q.beatCnt == 17'(BEAT_CYCLES - 1);
    assign calcEn   = runIn || st_q.cfg[IX_CTRL][CTRL_STOP_BIT];
    assign calcBeat = beat && calcEn;
    assign runRise  = runIn && !st_q.runPrev;
    assign mode     = st_q.cfg[IX_CTRL][1:0];
    assign th1      = st_q.cfg[IX_TH1];
    assign th2      = st_q.cfg[IX_TH2];
    assign sp       = (setpointIn > PCT_MAX) ? PCT_MAX : setpointIn;
    assign fb       = (feedbackIn > PCT_MAX) ? PCT_MAX : feedbackIn;
    assign fbF      = st_q.fbFilt >>> FRAC;
    assign e        = ppr_s32(sp) - fbF;
    assign absE     = (e < 0) ? 16'(-e) : e[15:0];
    assign lossBelow = st_q.cfg[IX_LTH] != 16'h0000 && fb < st_q.cfg[IX_LTH];
    assign lossLim   = ppr_s32(st_q.cfg[IX_LTIME]) * BEATS_100MS;

    always_comb begin
        pos  = 16'h0000;
        span = 16'h0001;
        case (mode)
            SW_TERM: begin
                pos = {15'h0000, multiFunctionInput};
            end
            SW_DEV: begin
                if (absE > th2) begin
                    pos = 16'h0001;
                end else if (absE >= th1) begin
                    pos  = absE - th1;
                    span = th2 - th1;
                end
            end
            // none and frequency use set one
            default: begin
                pos = 16'h0000;
            end
        endcase
    end

    assign kpAct = ppr_lerp(st_q.cfg[IX_KP1], st_q.cfg[IX_KP2], pos, span);
    assign tiAct = ppr_lerp(st_q.cfg[IX_TI1], st_q.cfg[IX_TI2], pos, span);
    assign tdAct = ppr_lerp(st_q.cfg[IX_TD1], st_q.cfg[IX_TD2], pos, span);

    always_comb begin
        pTerm = ppr_s32(kpAct) * e / KP_DIV;
        if (tiAct == 16'h0000) begin
            iNext = 32'sh00000000;
        end else begin
            iNext = ppr_clamp(st_q.integ + (e <<< IFRAC) / (ppr_s32(tiAct) * BEATS_10MS),
                              -(ppr_s32(PCT_MAX) <<< IFRAC), ppr_s32(PCT_MAX) <<< IFRAC);
        end
        dTerm = ppr_s32(tdAct) * (e - st_q.ePrev) / TD_DIV;
        raw   = ppr_clamp(pTerm + (iNext >>> IFRAC) + dTerm, 32'sh00000000, ppr_s32(PCT_MAX));
        outF  = ppr_lpf(st_q.outFilt, raw <<< FRAC, ppr_s32(st_q.cfg[IX_OUTF]) * BEATS_100MS);
        o     = ppr_clamp(outF >>> FRAC, ppr_s32(st_q.freq) - STEP_MAX, ppr_s32(st_q.freq) + STEP_MAX);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d = st_q;
        if (wrEn && cfgHit) begin
            st_d.cfg[idx] = wrVal;
        end else if (wrEn && paddr == OFS_STATUS && pwdata[ST_FAULT_BIT]) begin
            st_d.fault = 1'b0;
        end
        if (psel && !penable) begin
            st_d.prdata = rdVal;
        end
        st_d.beatCnt = beat ? 17'h00000 : st_q.beatCnt + 17'h00001;
        st_d.runPrev = runIn;
        if (beat) begin
            st_d.fbFilt = ppr_lpf(st_q.fbFilt, ppr_s32(fb) <<< FRAC,
                                  ppr_s32(st_q.cfg[IX_FBF]) * BEATS_10MS);
            if (!lossBelow) begin
                st_d.lossCnt = 16'h0000;
            end else if (ppr_s32(st_q.lossCnt) >= lossLim) begin
                st_d.fault = 1'b1;
            end else begin
                st_d.lossCnt = st_q.lossCnt + 16'h0001;
            end
        end
        if (runRise) begin
            st_d.phase   = PH_HOLD;
            st_d.holdCnt = 20'(ppr_s32(st_d.cfg[IX_ITIME]) * BEATS_10MS);
            st_d.freq    = st_d.cfg[IX_INIT];
            st_d.outFilt = ppr_s32(st_d.cfg[IX_INIT]) <<< FRAC;
            st_d.integ   = ppr_s32(st_d.cfg[IX_INIT]) <<< IFRAC;
            st_d.ePrev   = e;
        end else if (st_q.phase == PH_HOLD) begin
            if (!runIn) begin
                st_d.phase = PH_REG;
            end else begin
                st_d.freq = st_d.cfg[IX_INIT];
                if (beat && st_q.holdCnt == 20'h00000) begin
                    st_d.phase = PH_REG;
                    st_d.ePrev = e;
                end else if (beat) begin
                    st_d.holdCnt = st_q.holdCnt - 20'h00001;
                end
            end
        end else if (calcBeat) begin
            st_d.integ   = iNext;
            st_d.outFilt = outF;
            st_d.freq    = o[15:0];
            st_d.ePrev   = e;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q       <= '0;
            st_q.cfg   <= CFG_RST;
            st_q.phase <= PH_REG;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign prdata            = st_q.prdata;
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && !mapped;
    assign freqCmd           = st_q.freq;
    assign feedbackLossFault = st_q.fault;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_hold_init: assert property (st_q.phase == PH_HOLD |-> freqCmd == st_q.cfg[IX_INIT])
        else $error("output left the initial value during hold");
    a_step_limit: assert property ((st_q.phase == PH_REG && $past(st_q.phase) == PH_REG)
        |-> (ppr_s32(freqCmd) - ppr_s32($past(freqCmd)) <= STEP_MAX
             && ppr_s32($past(freqCmd)) - ppr_s32(freqCmd) <= STEP_MAX))
        else $error("output step between beats too large");
    a_loss_off: assert property ($rose(feedbackLossFault) |-> $past(st_q.cfg[IX_LTH]) != 16'h0000)
        else $error("loss fault raised with judgment disabled");
    a_loss_time: assert property ($rose(feedbackLossFault)
        |-> ppr_s32($past(st_q.lossCnt)) >= $past(lossLim) && $past(lossBelow) && $past(beat))
        else $error("loss fault raised before detection time");
    a_loss_clear: assert property ((beat && !lossBelow) |=> st_q.lossCnt == 16'h0000)
        else $error("loss timer kept counting above threshold");
    a_stop_hold: assert property ((beat && !calcEn && st_q.phase == PH_REG)
        |=> $stable(freqCmd) && $stable(st_q.integ))
        else $error("regulator computed while stopped");
    a_int_zero: assert property ((calcBeat && !runRise && st_q.phase == PH_REG
        && tiAct == 16'h0000) |=> st_q.integ == 32'sh00000000)
        else $error("integral kept with zero integration time");
    a_gain_none: assert property (mode == SW_NONE
        |-> kpAct == st_q.cfg[IX_KP1] && tiAct == st_q.cfg[IX_TI1])
        else $error("set one not used without switching");
    a_gain_term: assert property ((mode == SW_TERM && multiFunctionInput)
        |-> kpAct == st_q.cfg[IX_KP2] && tdAct == st_q.cfg[IX_TD2])
        else $error("terminal did not select set two");
    a_band_low: assert property ((mode == SW_DEV && absE < th1) |-> kpAct == st_q.cfg[IX_KP1])
        else $error("small deviation did not use set one");
    a_band_high: assert property ((mode == SW_DEV && absE > th2) |-> tiAct == st_q.cfg[IX_TI2])
        else $error("large deviation did not use set two");

endmodule : ppr_regulator

`default_nettype wire
